/* core/rsw_cfg.svh */
/*
  Constants of the redundancy switch: times, counts, register offsets,
  field positions, reset values and side-load display codes.
  Assumes a 25 MHz system clock; included by the package and modules.
*/
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH

// ==========================================================
// timing
`define RSW_CLK_HZ          25000000
`define RSW_TAKEOVER_S      13
`define RSW_TAKEOVER_CYCLES (`RSW_TAKEOVER_S * `RSW_CLK_HZ)
`define RSW_DEBOUNCE_US     100
`define RSW_DB_CYCLES       ((`RSW_CLK_HZ / 1000000) * `RSW_DEBOUNCE_US)
`define RSW_UNIT_DB_CYCLES  4
`define RSW_BOOT_EXTRA      8
`define RSW_CNT_W           16

// ==========================================================
// register map (byte addresses)
`define RSW_ADDR_W          8
`define RSW_OFF_CTRL        8'h00
`define RSW_OFF_STATUS      8'h04
`define RSW_OFF_IRQ_STAT    8'h08
`define RSW_OFF_IRQ_MASK    8'h0c
`define RSW_CTRL_LOAD_EN    0
`define RSW_CTRL_RESET      1'b1
`define RSW_IRQ_W           4
`define RSW_IRQ_SWITCH      0
`define RSW_IRQ_FAIL        1
`define RSW_IRQ_LOAD        2
`define RSW_IRQ_TAKEOVER    3

// ==========================================================
// side-load display codes
`define RSW_CODE_IDLE       8'h00
`define RSW_CODE_BD         8'hbd
`define RSW_CODE_BC         8'hbc
`define RSW_CODE_BA         8'hba

`endif

/* core/rsw_pkg.sv */
/*
  Types of the redundancy switch: unit, override and loader states,
  and the state record of the top module.
  Assumes rsw_cfg.svh is on the include path.
*/
`include "rsw_cfg.svh"

package rsw_pkg;

  // ==========================================================
  // states
  typedef enum logic [1:0] {RSW_DOWN = 2'b00, RSW_WAIT = 2'b01, RSW_LOAD = 2'b11, RSW_READY = 2'b10} rsw_unit_e;
  typedef enum logic [1:0] {RSW_AUTO = 2'b00, RSW_FORCE_A = 2'b01, RSW_FORCE_B = 2'b11} rsw_force_e;
  typedef enum logic [1:0] {RSW_LD_IDLE = 2'b00, RSW_LD_BD = 2'b01, RSW_LD_BC = 2'b11, RSW_LD_BA = 2'b10} rsw_load_e;

  // ==========================================================
  // top state record
  typedef struct packed {
    logic                        booted;
    logic [`RSW_CNT_W-1:0]       boot_cnt;
    logic                        online;
    logic [1:0]                  online_ind;
    logic [1:0]                  fail;
    rsw_unit_e [1:0]             ust;
    logic [31:0]                 wait_cnt;
    logic [1:0]                  st_q;
    rsw_force_e                  frc_q;
    logic [1:0]                  ld_start;
    logic                        ctrl_load_en;
    logic [`RSW_IRQ_W-1:0]       irq_stat;
    logic [`RSW_IRQ_W-1:0]       irq_mask;
    logic                        irq;
    logic                        dp_wr;
    logic [`RSW_ADDR_W-1:0]      dp_addr;
    logic [31:0]                 hrdata;
    logic                        hreadyout;
  } rsw_top_s;

endpackage : rsw_pkg

/* core/rsw_debounce.sv */
/*
  Two-flop synchroniser and debounce filter for a vector of pin inputs.
  Assumes inputs are asynchronous to clk; output changes after a level
  has held DB_CYCLES clocks.
*/
`timescale 1ns/10ps
`include "rsw_cfg.svh"

module rsw_debounce #(
  parameter int unsigned WIDTH     = 2,
  parameter int unsigned DB_CYCLES = `RSW_DB_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0]                  s1;
    logic [WIDTH-1:0]                  s2;
    logic [WIDTH-1:0]                  stable;
    logic [WIDTH-1:0][`RSW_CNT_W-1:0]  cnt;
  } rsw_db_s;

  rsw_db_s r;
  rsw_db_s r_nxt;

  // ==========================================================
  // filter
  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = din;
    r_nxt.s2 = r.s1;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] != r.stable[i]) begin
        r_nxt.cnt[i] = r.cnt[i] + 1'b1;
        if (r.cnt[i] == `RSW_CNT_W'(DB_CYCLES - 1)) begin
          r_nxt.stable[i] = r.s2[i];
          r_nxt.cnt[i]    = '0;
        end
      end else begin
        r_nxt.cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign dout = r.stable;

endmodule : rsw_debounce

/* core/rsw_loader.sv */
/*
  Side-load sequencer for one unit: steps the display code BD, BC, BA,
  one step per rising edge of the unit's acknowledge.
  Assumes ack is already synchronised; abort drops the load at once.
*/
`timescale 1ns/10ps
`include "rsw_cfg.svh"

module rsw_loader (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       ack,
  output logic      [7:0] code,
  output logic            busy,
  output logic            done
);

  typedef struct packed {
    rsw_pkg::rsw_load_e st;
    logic               ack_q;
    logic [7:0]         code;
    logic               busy;
    logic               done;
  } rsw_ld_s;

  rsw_ld_s r;
  rsw_ld_s r_nxt;
  logic    ack_rise;

  assign ack_rise = ack & ~r.ack_q;

  // ==========================================================
  // sequence
  always_comb begin
    r_nxt       = r;
    r_nxt.done  = 1'b0;
    r_nxt.ack_q = ack;
    if (abort) begin
      r_nxt.st   = rsw_pkg::RSW_LD_IDLE;
      r_nxt.code = `RSW_CODE_IDLE;
      r_nxt.busy = 1'b0;
    end else begin
      // [R5] display code steps
      case (r.st)
        rsw_pkg::RSW_LD_IDLE: begin
          if (start) begin
            r_nxt.st   = rsw_pkg::RSW_LD_BD;
            r_nxt.code = `RSW_CODE_BD;
            r_nxt.busy = 1'b1;
          end
        end
        rsw_pkg::RSW_LD_BD: begin
          if (ack_rise) begin
            r_nxt.st   = rsw_pkg::RSW_LD_BC;
            r_nxt.code = `RSW_CODE_BC;
          end
        end
        rsw_pkg::RSW_LD_BC: begin
          if (ack_rise) begin
            r_nxt.st   = rsw_pkg::RSW_LD_BA;
            r_nxt.code = `RSW_CODE_BA;
          end
        end
        rsw_pkg::RSW_LD_BA: begin
          if (ack_rise) begin
            r_nxt.st   = rsw_pkg::RSW_LD_IDLE;
            r_nxt.code = `RSW_CODE_IDLE;
            r_nxt.busy = 1'b0;
            r_nxt.done = 1'b1;
          end
        end
        default: begin
          r_nxt.st   = rsw_pkg::RSW_LD_IDLE;
          r_nxt.code = `RSW_CODE_IDLE;
          r_nxt.busy = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign code = r.code;
  assign busy = r.busy;
  assign done = r.done;

  // ==========================================================
  // checks
  sequence s_start_load;
    r.st == rsw_pkg::RSW_LD_IDLE && start && !abort;
  endsequence

  sequence s_step_bd;
    r.st == rsw_pkg::RSW_LD_BD && ack_rise && !abort;
  endsequence

  sequence s_step_bc;
    r.st == rsw_pkg::RSW_LD_BC && ack_rise && !abort;
  endsequence

  AST_LD_START_BD: assert property (@(posedge clk) disable iff (reset) // [R5]
    s_start_load |=> code == `RSW_CODE_BD && busy) else $error("load did not open with BD");

  AST_LD_BD_BC: assert property (@(posedge clk) disable iff (reset) // [R5]
    s_step_bd |=> code == `RSW_CODE_BC) else $error("BD not followed by BC");

  AST_LD_BC_BA: assert property (@(posedge clk) disable iff (reset) // [R5]
    s_step_bc |=> code == `RSW_CODE_BA ##1 !done || code == `RSW_CODE_BA) else $error("BC not followed by BA");

endmodule : rsw_loader

/* core/rsw_switch.sv */
/*
  Redundancy switch top: picks the online unit of two redundant processor
  modules, drives their fail and online indicators, runs side loads and
  the takeover timer, and offers an AHB-Lite register slave with interrupt.
  Assumes one 25 MHz clock; unit and selector inputs are asynchronous pins.
*/
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
// What this block does
// [R1] both fail indicators on until self-test done
// [R2] auto power-up: primary selector A goes online
// [R3] auto power-up: selector B puts B online
// [R4] online unit self-test done clears its fail
// [R5] backup side loaded, display BD, BC, BA
// [R6] B loaded: fail cleared, B stays offline
// [R7] online unit power loss moves online over
// [R8] returning unit: backup, loaded, then fail cleared
// [R9] force B: B online, A offline, A fails
// [R10] force A: A online, B offline, B fails
// [R11] dead primary: backup online after 13 s
// [R12] forced unit stays online without power
// [R13] inputs debounced, outputs registered, one online
`timescale 1ns/10ps
`include "rsw_cfg.svh"

module rsw_switch #(
  parameter int unsigned TAKEOVER_CYCLES = `RSW_TAKEOVER_CYCLES,
  parameter int unsigned DB_CYCLES       = `RSW_DB_CYCLES
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic [1:0]      unit_power_supply_good,
  input  wire logic [1:0]      unit_selftest_done,
  input  wire logic [1:0]      unit_load_ack,
  input  wire logic            primary_sel_b,
  input  wire logic            force_a_sel,
  input  wire logic            force_b_sel,
  output logic      [1:0]      unit_online_indicator,
  output logic      [1:0]      unit_fail_indicator,
  output logic      [1:0]      unit_side_load_en,
  output logic      [1:0][7:0] unit_load_code,
  output logic                 irq
);

  localparam int unsigned BOOT_CYCLES = DB_CYCLES + `RSW_BOOT_EXTRA;

  rsw_pkg::rsw_top_s     r;
  rsw_pkg::rsw_top_s     r_nxt;
  logic [1:0]            pwr;
  logic [1:0]            st;
  logic [1:0]            ack;
  logic [2:0]            sw;
  logic [1:0]            ld_done;
  logic [1:0]            ld_abort;
  logic [1:0]            st_rise;
  rsw_pkg::rsw_force_e   frc;
  logic                  fedge;
  logic [31:0]           status_word;

  // ==========================================================
  // input conditioning
  // [R13] switch and power debounce
  rsw_debounce #(.WIDTH(5), .DB_CYCLES(DB_CYCLES)) u_db_slow (
    .clk   (clk),
    .reset (reset),
    .din   ({primary_sel_b, force_b_sel, force_a_sel, unit_power_supply_good}),
    .dout  ({sw, pwr})
  );

  rsw_debounce #(.WIDTH(4), .DB_CYCLES(`RSW_UNIT_DB_CYCLES)) u_db_unit (
    .clk   (clk),
    .reset (reset),
    .din   ({unit_load_ack, unit_selftest_done}),
    .dout  ({ack, st})
  );

  assign frc         = sw[1] ? rsw_pkg::RSW_FORCE_B : (sw[0] ? rsw_pkg::RSW_FORCE_A : rsw_pkg::RSW_AUTO);
  assign fedge       = r.booted && frc != r.frc_q && frc != rsw_pkg::RSW_AUTO;
  assign st_rise     = st & ~r.st_q;
  assign ld_abort    = ~pwr;
  assign status_word = {22'h0, r.ust[1], r.ust[0], pwr, r.fail, r.online_ind};

  // ==========================================================
  // side loaders
  for (genvar g = 0; g < 2; g++) begin : g_ld
    // [R5] side load per unit
    rsw_loader u_ld (
      .clk   (clk),
      .reset (reset),
      .start (r.ld_start[g]),
      .abort (ld_abort[g]),
      .ack   (ack[g]),
      .code  (unit_load_code[g]),
      .busy  (unit_side_load_en[g]),
      .done  (ld_done[g])
    );
  end

  // ==========================================================
  // switchover and registers
  always_comb begin
    logic [`RSW_IRQ_W-1:0] ev;
    logic [`RSW_IRQ_W-1:0] w1c;
    int                    j;
    ev             = '0;
    w1c            = '0;
    j              = 0;
    r_nxt          = r;
    r_nxt.st_q     = st;
    r_nxt.frc_q    = frc;
    r_nxt.ld_start = '0;
    if (!r.booted) begin
      // [R1] both units failed at power-up
      r_nxt.fail     = 2'b11;
      r_nxt.boot_cnt = r.boot_cnt + 1'b1;
      // [R2] [R3] primary or forced unit
      r_nxt.online   = (frc == rsw_pkg::RSW_AUTO) ? sw[2] : (frc == rsw_pkg::RSW_FORCE_B);
      if (r.boot_cnt == `RSW_CNT_W'(BOOT_CYCLES - 1)) begin
        r_nxt.booted = 1'b1;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        j = 1 - i;
        if (!pwr[i]) begin
          r_nxt.ust[i]  = rsw_pkg::RSW_DOWN;
          r_nxt.fail[i] = 1'b1;
          // [R7] power loss moves online
          // [R12] forced unit held online
          // a primary that never came up waits for the takeover timer
          if (r.online == 1'(i) && frc == rsw_pkg::RSW_AUTO && pwr[j]
              && (r.ust[i] != rsw_pkg::RSW_DOWN || r.ust[j] == rsw_pkg::RSW_READY)) begin
            r_nxt.online = 1'(j);
          end
        end else begin
          case (r.ust[i])
            rsw_pkg::RSW_DOWN: begin
              if (st_rise[i]) begin
                if (r.online == 1'(i)) begin
                  // [R4] online unit ready
                  r_nxt.ust[i]  = rsw_pkg::RSW_READY;
                  r_nxt.fail[i] = 1'b0;
                end else if (pwr[j] && r.ust[j] == rsw_pkg::RSW_READY && r.ctrl_load_en) begin
                  // [R8] returning unit is backup
                  r_nxt.ust[i]      = rsw_pkg::RSW_LOAD;
                  r_nxt.ld_start[i] = 1'b1;
                end else begin
                  r_nxt.ust[i]   = rsw_pkg::RSW_WAIT;
                  r_nxt.wait_cnt = '0;
                end
              end
            end
            rsw_pkg::RSW_WAIT: begin
              r_nxt.wait_cnt = r.wait_cnt + 1'b1;
              if (pwr[j] && r.ust[j] == rsw_pkg::RSW_READY && r.ctrl_load_en) begin
                r_nxt.ust[i]      = rsw_pkg::RSW_LOAD;
                r_nxt.ld_start[i] = 1'b1;
              end else if (r.wait_cnt >= 32'(TAKEOVER_CYCLES - 1) && frc == rsw_pkg::RSW_AUTO) begin
                // [R11] takeover after wait
                r_nxt.online   = 1'(i);
                r_nxt.ust[i]   = rsw_pkg::RSW_DOWN;
                ev[`RSW_IRQ_TAKEOVER] = 1'b1;
              end
            end
            rsw_pkg::RSW_LOAD: begin
              if (ld_done[i]) begin
                // [R6] [R8] loaded backup ready
                r_nxt.ust[i]  = rsw_pkg::RSW_READY;
                r_nxt.fail[i] = 1'b0;
              end
            end
            rsw_pkg::RSW_READY: begin
            end
            default: begin
              r_nxt.ust[i] = rsw_pkg::RSW_DOWN;
            end
          endcase
        end
      end
      if (fedge) begin
        j = (frc == rsw_pkg::RSW_FORCE_B) ? 0 : 1;
        // [R9] [R10] forced switchover
        if (r.online == 1'(j)) begin
          r_nxt.online  = 1'(1 - j);
          r_nxt.ust[j]  = rsw_pkg::RSW_DOWN;
          r_nxt.fail[j] = 1'b1;
        end
      end
    end
    // [R13] exactly one online
    r_nxt.online_ind = {r_nxt.online, ~r_nxt.online};
    ev[`RSW_IRQ_SWITCH] = r.booted && r_nxt.online != r.online;
    ev[`RSW_IRQ_FAIL]   = r.booted && |(r_nxt.fail & ~r.fail);
    ev[`RSW_IRQ_LOAD]   = |ld_done;
    // bus data phase
    if (r.dp_wr) begin
      case (r.dp_addr)
        `RSW_OFF_CTRL:     r_nxt.ctrl_load_en = hwdata[`RSW_CTRL_LOAD_EN];
        `RSW_OFF_IRQ_STAT: w1c = hwdata[`RSW_IRQ_W-1:0];
        `RSW_OFF_IRQ_MASK: r_nxt.irq_mask = hwdata[`RSW_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // set wins over clear
    r_nxt.irq_stat = (r.irq_stat & ~w1c) | ev;
    r_nxt.irq      = |(r_nxt.irq_stat & r_nxt.irq_mask);
    // bus address phase
    r_nxt.dp_wr  = 1'b0;
    r_nxt.hrdata = '0;
    if (hsel && hready && htrans[1]) begin
      r_nxt.dp_wr   = hwrite;
      r_nxt.dp_addr = haddr[`RSW_ADDR_W-1:0];
      if (!hwrite) begin
        case (haddr[`RSW_ADDR_W-1:0])
          `RSW_OFF_CTRL:     r_nxt.hrdata = {31'h0, r.ctrl_load_en};
          `RSW_OFF_STATUS:   r_nxt.hrdata = status_word;
          `RSW_OFF_IRQ_STAT: r_nxt.hrdata = {28'h0, r.irq_stat};
          `RSW_OFF_IRQ_MASK: r_nxt.hrdata = {28'h0, r.irq_mask};
          default:           r_nxt.hrdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r              <= '0;
      r.fail         <= 2'b11;
      r.online_ind   <= 2'b01;
      r.ctrl_load_en <= `RSW_CTRL_RESET;
      r.hreadyout    <= 1'b1;
    end else begin
      r <= r_nxt;
    end
  end

  assign hrdata                = r.hrdata;
  assign hreadyout             = r.hreadyout;
  assign hresp                 = 1'b0 & r.hreadyout;
  assign unit_online_indicator = r.online_ind;
  assign unit_fail_indicator   = r.fail;
  assign irq                   = r.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_BOOT_FAIL: assert property (!r.booted |-> unit_fail_indicator == 2'b11) // [R1]
    else $error("fail indicators not both on before boot");

  AST_BOOT_A: assert property ($rose(r.booted) && frc == rsw_pkg::RSW_AUTO && !sw[2] // [R2]
    |-> unit_online_indicator == 2'b01) else $error("primary A not online at boot");

  AST_BOOT_B: assert property ($rose(r.booted) && frc == rsw_pkg::RSW_AUTO && sw[2] // [R3]
    |-> unit_online_indicator == 2'b10) else $error("primary B not online at boot");

  AST_SELFTEST_ONLINE: assert property (r.booted && pwr[0] && st_rise[0] && !r.online // [R4]
    && r.ust[0] == rsw_pkg::RSW_DOWN && !fedge |=> !unit_fail_indicator[0] && unit_online_indicator[0])
    else $error("online A self-test did not clear fail");

  AST_LOAD_DONE_B: assert property (r.booted && pwr == 2'b11 && r.ust[1] == rsw_pkg::RSW_LOAD // [R6]
    && ld_done[1] && !fedge |=> !unit_fail_indicator[1] && !unit_online_indicator[1])
    else $error("loaded B not cleared or went online");

  AST_POWER_LOSS_A: assert property (r.booted && !r.online && !pwr[0] && pwr[1] // [R7]
    && (r.ust[0] != rsw_pkg::RSW_DOWN || r.ust[1] == rsw_pkg::RSW_READY)
    && frc == rsw_pkg::RSW_AUTO && !fedge |=> unit_online_indicator == 2'b10 && unit_fail_indicator[0])
    else $error("power loss of A did not move online to B");

  AST_RETURN_BACKUP: assert property (r.booted && pwr == 2'b11 && r.online && st_rise[0] // [R8]
    && r.ust[0] == rsw_pkg::RSW_DOWN && r.ust[1] == rsw_pkg::RSW_READY && r.ctrl_load_en && !fedge
    |=> r.ust[0] == rsw_pkg::RSW_LOAD ##1 unit_side_load_en[0] && !unit_online_indicator[0])
    else $error("returning A not side loaded as backup");

  AST_FORCE_B: assert property (fedge && frc == rsw_pkg::RSW_FORCE_B && !r.online // [R9]
    |=> unit_online_indicator == 2'b10 && unit_fail_indicator[0]) else $error("force B failed");

  AST_FORCE_A: assert property (fedge && frc == rsw_pkg::RSW_FORCE_A && r.online // [R10]
    |=> unit_online_indicator == 2'b01 && unit_fail_indicator[1]) else $error("force A failed");

  AST_TAKEOVER_B: assert property (r.booted && !r.online && r.ust[1] == rsw_pkg::RSW_WAIT && pwr == 2'b10 // [R11]
    && r.wait_cnt == 32'(TAKEOVER_CYCLES - 1) && frc == rsw_pkg::RSW_AUTO |=> unit_online_indicator == 2'b10)
    else $error("B not taken online after wait");

  AST_TAKEOVER_A: assert property (r.booted && r.online && r.ust[0] == rsw_pkg::RSW_WAIT && pwr == 2'b01 // [R11]
    && r.wait_cnt == 32'(TAKEOVER_CYCLES - 1) && frc == rsw_pkg::RSW_AUTO |=> unit_online_indicator == 2'b01)
    else $error("A not taken online after wait");

  AST_FORCED_HOLD: assert property (r.booted && frc == rsw_pkg::RSW_FORCE_B && r.online && !pwr[1] // [R12]
    && !fedge |=> unit_online_indicator == 2'b10 [*2] ) else $error("forced B dropped offline");

  AST_ONE_ONLINE: assert property ($onehot(unit_online_indicator)) // [R13]
    else $error("not exactly one unit online");

endmodule : rsw_switch

/* verification/rsw_unit_model.sv */
/*
  Model of the two redundant processor units: a self-test after power
  comes up, and one acknowledge pulse for each new side-load display code.
  Assumes the clock of the switch; rerun restarts a unit's self-test.
*/
`timescale 1ns/10ps

module rsw_unit_model #(
  parameter int ST_BASE = 40
) (
  input  wire logic            clk,
  input  wire logic [1:0]      power,
  input  wire logic [1:0]      rerun,
  input  wire logic [1:0]      load_en,
  input  wire logic [1:0][7:0] load_code,
  output logic      [1:0]      selftest_done,
  output logic      [1:0]      load_ack
);
  // ==========================================================
  // per-unit behaviour
  int         st_cnt [2];
  int         ak_cnt [2];
  logic [7:0] seen   [2];

  initial begin
    selftest_done = 2'b00;
    load_ack      = 2'b00;
  end

  for (genvar i = 0; i < 2; i++) begin : g_unit
    always @(posedge clk) begin
      if (!power[i] || rerun[i]) begin
        st_cnt[i]        <= 0;
        selftest_done[i] <= 1'b0;
      end else if (st_cnt[i] < ST_BASE + 20 * i) begin
        st_cnt[i] <= st_cnt[i] + 1;
      end else begin
        selftest_done[i] <= 1'b1;
      end
    end
    // one ack pulse per new code
    always @(posedge clk) begin
      if (!load_en[i] || !power[i]) begin
        seen[i]     <= 8'h00;
        ak_cnt[i]   <= 0;
        load_ack[i] <= 1'b0;
      end else if (ak_cnt[i] != 0) begin
        ak_cnt[i]   <= (ak_cnt[i] == 24) ? 0 : ak_cnt[i] + 1;
        load_ack[i] <= (ak_cnt[i] >= 4 && ak_cnt[i] < 14);
      end else if (load_code[i] != seen[i]) begin
        seen[i]   <= load_code[i];
        ak_cnt[i] <= 1;
      end
    end
  end
endmodule : rsw_unit_model

/* verification/rsw_switch_bench.sv */
/*
  Self-checking bench of the redundancy switch: boot, side loads, power
  loss, forced switchover, takeover, register slave and interrupt.
  Assumes the unit model answers for both processor units.
*/
`timescale 1ns/10ps

module rsw_switch_bench;
  logic            clk, reset, hsel, hwrite, hreadyout, hresp, irq, psel, fa, fb;
  logic [31:0]     haddr, hwdata, hrdata, rd, rnd;
  logic [1:0]      htrans, pwr, rerun, st, ack, on, fl, len;
  logic [1:0][7:0] code;
  logic [23:0]     sq [2];
  int              failures, total_checks;

  rsw_switch #(.TAKEOVER_CYCLES(50), .DB_CYCLES(4)) dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .unit_power_supply_good(pwr), .unit_selftest_done(st), .unit_load_ack(ack),
    .primary_sel_b(psel), .force_a_sel(fa), .force_b_sel(fb), .unit_online_indicator(on),
    .unit_fail_indicator(fl), .unit_side_load_en(len), .unit_load_code(code), .irq(irq));
  rsw_unit_model units (.clk(clk), .power(pwr), .rerun(rerun), .load_en(len), .load_code(code),
    .selftest_done(st), .load_ack(ack));

  // ==========================================================
  // clock, load display record
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) if (len[i] === 1'b1 && code[i] !== sq[i][7:0]) sq[i] <= {sq[i][15:0], code[i]};
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic wt(input logic [1:0] o, input logic [1:0] f);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ({on, fl} !== {o, f} && n < 900);
    chk(32'({on, fl}), 32'({o, f}));
    if ({on, fl} !== {o, f}) test_done();
  endtask : wt

  task automatic ld(input int i);
    chk(32'(sq[i]), 32'h00bdbcba);
    sq[i] <= 24'h0;
  endtask : ld

  task automatic rr(input int i);
    @(posedge clk);
    rerun[i] <= 1'b1;
    repeat (10) @(posedge clk);
    rerun[i] <= 1'b0;
  endtask : rr

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
      rd = hrdata;
    end while (hreadyout !== 1'b1 && n < 100);
    chk(32'(hresp), 32'h0);
    if (n >= 100) begin
      failures++;
      test_done();
    end
  endtask : bus

  // ==========================================================
  // scenarios
  initial begin
    {hsel, hwrite, psel, fa, fb} = 5'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    pwr = 2'b11;
    rerun = 2'b00;
    failures = 0;
    total_checks = 0;
    rnd = 32'h7817130c;
    sq = '{24'h0, 24'h0};
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    wt(2'b01, 2'b11);
    wt(2'b01, 2'b10);
    wt(2'b01, 2'b00);
    ld(1);
    pwr <= 2'b10;
    wt(2'b10, 2'b01);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h7);
    rnd = lfsr(rnd);
    bus(1'b1, 8'h0c, rnd);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, {28'h0, rnd[3:0]});
    chk(32'(irq), 32'(|(rnd[2:0])));
    bus(1'b1, 8'h0c, 32'hf);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h7);
    chk(32'(irq), 32'h1);
    bus(1'b1, 8'h08, 32'hf);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    chk(32'(rd[3:0]), 32'h6);
    pwr <= 2'b11;
    wt(2'b10, 2'b00);
    ld(0);
    fa <= 1'b1;
    wt(2'b01, 2'b10);
    rr(1);
    wt(2'b01, 2'b00);
    ld(1);
    fa <= 1'b0;
    fb <= 1'b1;
    wt(2'b10, 2'b01);
    rr(0);
    wt(2'b10, 2'b00);
    ld(0);
    pwr <= 2'b01;
    wt(2'b10, 2'b10);
    repeat (80) @(posedge clk);
    wt(2'b10, 2'b10);
    pwr <= 2'b11;
    wt(2'b10, 2'b00);
    fb <= 1'b0;
    psel <= 1'b1;
    pwr <= 2'b01;
    rerun <= 2'b11;
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rerun <= 2'b00;
    wt(2'b10, 2'b11);
    wt(2'b01, 2'b11);
    rr(0);
    wt(2'b01, 2'b10);
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : rsw_switch_bench
